// file: rtl/evrup_pkg.sv
// constants for the event record upload block
// Function
// - page 35h reads return a stored record without changing its acknowledgement.
// - event slots sit at words 3500h to 35F9h, up to 75 records.
// - page 36h reads return the oldest record not yet acknowledged.
// - control word 400h bit 12 selects manual (1) or automatic (0) acknowledgement.
// - automatic mode: reading word 9 (the flag word) of the oldest unacknowledged record through page 36h acknowledges it.
// - manual mode: writing one to control bit 13 acknowledges the oldest record.
// - each record is nine 16-bit words, read as single words.
// - words: event code, source address, value, reserved, then four timestamp words.
// - timestamp format follows the date format setting at 012Fh, private or IEC.
// - word 9 reads 0 while unacknowledged, 1 once acknowledged.
// - event code in word 1 uses the decimal event table, as supplied.
package evrup_pkg;
  localparam logic [15:0] CTRL_ADDR       = 16'h0400;
  localparam logic [15:0] DATEFMT_ADDR    = 16'h012f;
  localparam logic [15:0] PAGE35_FIRST    = 16'h3500;
  localparam logic [15:0] PAGE35_LAST     = 16'h35f9;
  localparam logic [7:0]  PAGE36_HI       = 8'h36;
  localparam int          NUM_RECORDS     = 75;
  localparam int          REC_WORDS       = 9;
  localparam logic [3:0]  ACK_WORD_IDX    = 4'h8;
  localparam int          CTRL_MANUAL_BIT = 12;
  localparam int          CTRL_ACK_BIT    = 13;
  localparam logic [15:0] CTRL_RESET      = 16'h0000;
  localparam logic        DATEFMT_RESET   = 1'b0;
  localparam int          STORED_BITS     = 112;
  localparam int          FIFO_DEPTH      = 4;
endpackage

// file: rtl/evrup_core.sv
// event record store, acknowledge logic and its input fifo
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// input fifo
// ----------------------------------------------------------------
module evrup_fifo #(
  parameter int WIDTH = 112,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  // fill side
  input  wire logic             i_valid,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_ready,
  // drain side
  output logic                  o_valid,
  output logic [WIDTH-1:0]      o_data,
  input  wire logic             i_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ff, rd_ff, nxt_wr, nxt_rd;
  logic             push, pop;

  always_comb begin
    o_ready = (wr_ff - rd_ff) != (AW+1)'(DEPTH);
    o_valid = wr_ff != rd_ff;
    o_data  = mem[rd_ff[AW-1:0]];
    push    = i_valid & o_ready;
    pop     = o_valid & i_ready;
    nxt_wr  = push ? wr_ff + 1'b1 : wr_ff;
    nxt_rd  = pop ? rd_ff + 1'b1 : rd_ff;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
    end
    if (push) begin
      mem[wr_ff[AW-1:0]] <= i_data;
    end
  end
endmodule

// ----------------------------------------------------------------
// record store and register access
// ----------------------------------------------------------------
module evrup_core
  import evrup_pkg::*;
#(
  parameter int NREC = NUM_RECORDS
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // event source
  input  wire logic        i_evt_valid,
  input  wire logic [15:0] i_evt_code,
  input  wire logic [15:0] i_evt_src_addr,
  input  wire logic [15:0] i_evt_value,
  input  wire logic [63:0] i_evt_date_private,
  input  wire logic [63:0] i_evt_date_iec,
  output logic             o_evt_ready,
  // register access
  input  wire logic        i_rd,
  input  wire logic        i_wr,
  input  wire logic [15:0] i_addr,
  input  wire logic [3:0]  i_word,
  input  wire logic [15:0] i_wdata,
  output logic [15:0]      o_rdata,
  output logic             o_rvalid,
  // status
  output logic [6:0]       o_unacked,
  output logic             o_manual_mode
);
  initial begin
    if (NREC < 1 || NREC > (PAGE35_LAST - PAGE35_FIRST + 1)) $error("record count out of page range");
    if (NREC >= 2 ** 7) $error("record count too large for the seven bit counters");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [6:0] inc_idx(input logic [6:0] idx);
    inc_idx = (idx == 7'(NREC - 1)) ? 7'h00 : idx + 7'h01;
  endfunction

  // record layout: code, source, value, reserved, four date words, ack
  function automatic logic [15:0] rec_word(input logic [STORED_BITS-1:0] rec, input logic ok,
                                           input logic ack, input logic [3:0] w);
    logic [15:0] r;
    r = 16'h0000;
    if (ok) begin
      unique case (w)
        4'h0: r = rec[111:96];
        4'h1: r = rec[95:80];
        4'h2: r = rec[79:64];
        4'h4: r = rec[63:48];
        4'h5: r = rec[47:32];
        4'h6: r = rec[31:16];
        4'h7: r = rec[15:0];
        4'h8: r = {15'h0000, ack};
        default: r = 16'h0000;
      endcase
    end
    rec_word = r;
  endfunction

  // ----------------------------------------------------------------
  // input fifo
  // ----------------------------------------------------------------
  logic [STORED_BITS-1:0] fifo_in, fifo_out;
  logic                   fifo_valid, fifo_ready, datefmt_ff, evt_take, evt_ready_ff;

  // timestamp chosen at capture so a later format change leaves old records intact
  assign fifo_in = {i_evt_code, i_evt_src_addr, i_evt_value,
                    datefmt_ff ? i_evt_date_iec : i_evt_date_private};

  // reads own the store port, so a read cycle stalls the drain
  assign fifo_ready = ~i_rd;

  // taken only on an edge that showed ready outside, never behind the source's back
  assign evt_take = i_evt_valid & evt_ready_ff;

  evrup_fifo #(.WIDTH(STORED_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_valid (evt_take),
    .i_data  (fifo_in),
    .o_ready (),
    .o_valid (fifo_valid),
    .o_data  (fifo_out),
    .i_ready (fifo_ready)
  );

  // ----------------------------------------------------------------
  // record store state
  // ----------------------------------------------------------------
  logic [STORED_BITS-1:0] store [NREC];
  logic [NREC-1:0]        used_ff, acked_ff, nxt_used, nxt_acked;
  logic [6:0]             wr_ff, ackp_ff, cnt_ff, unack_ff;
  logic [6:0]             nxt_wr, nxt_ackp, nxt_cnt, nxt_unack;
  logic [15:0]            ctrl_ff, nxt_ctrl;
  logic                   nxt_datefmt, push, ack_req, manual;
  logic                   sel35, sel36;
  logic [15:0]            slot_off;
  logic [6:0]             slot;

  assign manual   = ctrl_ff[CTRL_MANUAL_BIT];
  assign push     = fifo_valid & fifo_ready;
  assign slot_off = i_addr - PAGE35_FIRST;
  assign slot     = slot_off[6:0];
  assign sel35    = (i_addr >= PAGE35_FIRST) && (i_addr <= PAGE35_LAST);
  assign sel36    = i_addr[15:8] == PAGE36_HI;

  // only the oldest unacknowledged record can ever be acknowledged
  assign ack_req = (unack_ff != 7'h00) &&
                   ((!manual && i_rd && sel36 && i_word == ACK_WORD_IDX) ||
                    (manual && i_wr && i_addr == CTRL_ADDR && i_wdata[CTRL_ACK_BIT]));

  always_comb begin
    nxt_used    = used_ff;
    nxt_acked   = acked_ff;
    nxt_wr      = wr_ff;
    nxt_ackp    = ackp_ff;
    nxt_cnt     = cnt_ff;
    nxt_unack   = unack_ff;
    nxt_ctrl    = ctrl_ff;
    nxt_datefmt = datefmt_ff;
    if (i_wr && i_addr == CTRL_ADDR) begin
      nxt_ctrl = i_wdata;
      nxt_ctrl[CTRL_ACK_BIT] = 1'b0;
    end
    if (i_wr && i_addr == DATEFMT_ADDR) begin
      nxt_datefmt = i_wdata[0];
    end
    if (ack_req) begin
      nxt_acked[ackp_ff] = 1'b1;
      nxt_ackp  = inc_idx(ackp_ff);
      nxt_unack = unack_ff - 7'h01;
    end
    if (push) begin
      nxt_used[wr_ff]  = 1'b1;
      nxt_acked[wr_ff] = 1'b0;
      nxt_wr = inc_idx(wr_ff);
      if (cnt_ff != 7'(NREC)) begin
        nxt_cnt   = cnt_ff + 7'h01;
        nxt_unack = nxt_unack + 7'h01;
      end else if (nxt_unack == 7'(NREC)) begin
        // full and nothing acknowledged: the oldest is overwritten
        nxt_ackp = inc_idx(nxt_ackp);
      end else begin
        nxt_unack = nxt_unack + 7'h01;
      end
      if (nxt_unack == 7'h01 && cnt_ff != 7'(NREC) && !ack_req && unack_ff == 7'h00) begin
        nxt_ackp = wr_ff;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      used_ff    <= '0;
      acked_ff   <= '0;
      wr_ff      <= 7'h00;
      ackp_ff    <= 7'h00;
      cnt_ff     <= 7'h00;
      unack_ff   <= 7'h00;
      ctrl_ff    <= CTRL_RESET;
      datefmt_ff <= DATEFMT_RESET;
    end else begin
      used_ff    <= nxt_used;
      acked_ff   <= nxt_acked;
      wr_ff      <= nxt_wr;
      ackp_ff    <= nxt_ackp;
      cnt_ff     <= nxt_cnt;
      unack_ff   <= nxt_unack;
      ctrl_ff    <= nxt_ctrl;
      datefmt_ff <= nxt_datefmt;
    end
    if (push) begin
      store[wr_ff] <= fifo_out;
    end
  end

  // ----------------------------------------------------------------
  // fifo occupancy
  // ----------------------------------------------------------------
  // mirrored here so o_evt_ready comes straight from a flop
  localparam int FCW = $clog2(FIFO_DEPTH) + 1;
  logic [FCW-1:0] fcnt_ff, nxt_fcnt;
  logic           nxt_evt_ready;

  always_comb begin
    nxt_fcnt = fcnt_ff;
    if (evt_take && !push) begin
      nxt_fcnt = fcnt_ff + 1'b1;
    end else if (push && !evt_take) begin
      nxt_fcnt = fcnt_ff - 1'b1;
    end
    nxt_evt_ready = nxt_fcnt != FCW'(FIFO_DEPTH);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      fcnt_ff      <= '0;
      evt_ready_ff <= 1'b0;
    end else begin
      fcnt_ff      <= nxt_fcnt;
      evt_ready_ff <= nxt_evt_ready;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [15:0] rdata_ff, nxt_rdata;
  logic        rvalid_ff, manual_ff;
  logic [6:0]  unacked_ff;
  logic        slot_ok;

  assign slot_ok = sel35 && slot_off < 16'(NREC);

  always_comb begin
    nxt_rdata = 16'h0000;
    if (i_rd) begin
      if (slot_ok) begin
        nxt_rdata = rec_word(store[slot], used_ff[slot], acked_ff[slot], i_word);
      end else if (sel36) begin
        // nothing left unacknowledged: an all-zero record, event code zero
        nxt_rdata = rec_word(store[ackp_ff], unack_ff != 7'h00, 1'b0, i_word);
      end else if (i_addr == CTRL_ADDR) begin
        nxt_rdata = ctrl_ff;
      end else if (i_addr == DATEFMT_ADDR) begin
        nxt_rdata = {15'h0000, datefmt_ff};
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      rdata_ff     <= 16'h0000;
      rvalid_ff    <= 1'b0;
      unacked_ff   <= 7'h00;
      manual_ff    <= 1'b0;
    end else begin
      rdata_ff     <= nxt_rdata;
      rvalid_ff    <= i_rd;
      unacked_ff   <= nxt_unack;
      manual_ff    <= nxt_ctrl[CTRL_MANUAL_BIT];
    end
  end

  assign o_rdata       = rdata_ff;
  assign o_rvalid      = rvalid_ff;
  assign o_evt_ready   = evt_ready_ff;
  assign o_unacked     = unacked_ff;
  assign o_manual_mode = manual_ff;
endmodule

`default_nettype wire

// file: verif/evrup_asserts.sv
// concurrent checks on the event record upload core ports
`timescale 1ns/10ps
`default_nettype none
module evrup_asserts
  import evrup_pkg::*;
#(parameter int NREC = NUM_RECORDS) (
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_rstn,
  // register access
  input wire logic        i_rd,
  input wire logic        i_wr,
  input wire logic [15:0] i_addr,
  input wire logic [3:0]  i_word,
  input wire logic [15:0] i_wdata,
  input wire logic [15:0] o_rdata,
  input wire logic        o_rvalid,
  // status
  input wire logic [6:0]  o_unacked,
  input wire logic        o_manual_mode
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // reads stall the fifo drain, so no store write can hide a count step
  wire logic rd36 = i_rd && !i_wr && i_addr[15:8] == PAGE36_HI;
  wire logic ctl  = i_wr && !i_rd && i_addr == CTRL_ADDR;
  AST_ANSWER: assert property (i_rd |=> o_rvalid) else $error("read not answered");
  AST_QUIET: assert property (!i_rd |=> !o_rvalid && o_rdata == 16'h0) else $error("stray answer");
  AST_RSVD: assert property (
    i_rd && i_word == 4'h3 && (i_addr[15:8] == 8'h35 || i_addr[15:8] == PAGE36_HI)
    |=> o_rdata == 16'h0) else $error("reserved word");
  AST_SPARE: assert property (
    i_rd && i_addr >= 16'h3500 + NREC && i_addr <= PAGE35_LAST |=> o_rdata == 16'h0) else $error("spare slot");
  AST_FLAG: assert property (
    i_rd && i_word == ACK_WORD_IDX && i_addr[15:9] == 7'h1a |=> o_rdata <= 16'h1) else $error("flag word");
  AST_MODE: assert property (
    ctl |=> o_manual_mode == $past(i_wdata[CTRL_MANUAL_BIT])) else $error("mode bit");
  AST_AUTO: assert property (
    rd36 && i_word == ACK_WORD_IDX && !o_manual_mode && o_unacked != 7'h0
    |=> o_unacked == $past(o_unacked) - 7'h1) else $error("auto ack");
  AST_HOLD35: assert property (
    i_rd && !i_wr && i_addr[15:8] == 8'h35 |=> o_unacked >= $past(o_unacked)) else $error("page 35 acked");
  AST_MANHOLD: assert property (rd36 && o_manual_mode |=> o_unacked >= $past(o_unacked)) else $error("read acked");
  AST_MANACK: assert property (
    ctl && i_wdata[CTRL_ACK_BIT] && i_wdata[CTRL_MANUAL_BIT] && o_manual_mode && o_unacked != 7'h0
    |=> o_unacked <= $past(o_unacked)) else $error("manual ack");
  cover property (rd36 && i_word == ACK_WORD_IDX && !o_manual_mode && o_unacked != 7'h0);
  cover property (ctl && i_wdata[CTRL_ACK_BIT] && o_manual_mode);
  cover property (i_rd && i_addr[15:8] == 8'h35);
endmodule
bind evrup_core evrup_asserts #(.NREC(NREC)) u_chk (.i_clk, .i_rstn, .i_rd, .i_wr, .i_addr, .i_word,
  .i_wdata, .o_rdata, .o_rvalid, .o_unacked, .o_manual_mode);
`default_nettype wire

// file: verif/evrup_master.sv
// master station model: single word reads and control writes
`timescale 1ns/10ps
`default_nettype none
module evrup_master (
  // clock and answer
  input  wire logic        i_clk,
  input  wire logic [15:0] i_rdata,
  // request
  output logic             o_rd,
  output logic             o_wr,
  output logic [15:0]      o_addr,
  output logic [3:0]       o_word,
  output logic [15:0]      o_wdata
);
  initial begin
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_addr = 16'h0;
    o_word = 4'h0;
    o_wdata = 16'h0;
  end
  // released lines flip so a stale value cannot pass for a held one
  task automatic park();
    o_addr = ~o_addr;
    o_word = ~o_word;
    o_wdata = ~o_wdata;
  endtask
  task automatic rd(input logic [15:0] a, input logic [3:0] w, output logic [15:0] d);
    o_rd = 1'b1;
    o_addr = a;
    o_word = w;
    @(posedge i_clk);
    #1 o_rd = 1'b0;
    park();
    d = i_rdata;
    @(posedge i_clk);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    o_wr = 1'b1;
    o_addr = a;
    o_wdata = v;
    @(posedge i_clk);
    #1 o_wr = 1'b0;
    park();
    @(posedge i_clk);
    #1;
  endtask
  // back to back reads of an unmapped word hold the fifo drain off
  task automatic stall(input int n);
    o_rd = 1'b1;
    o_addr = 16'h1000;
    o_word = 4'h0;
    repeat (n) @(posedge i_clk);
    #1 o_rd = 1'b0;
    park();
    @(posedge i_clk);
    #1;
  endtask
endmodule
`default_nettype wire

// file: verif/event_record_upload_bench.sv
// self-checking bench for the event record upload core
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin $display("unexpected %s exp %h got %h", n, e, g); num_errors++; end end
module event_record_upload_bench
  import evrup_pkg::*;
;
  logic        clk = 1'b0, rstn = 1'b0, ev = 1'b0, fmt = 1'b0, rd, wr, rdy, mm;
  logic [15:0] c = 16'h0, s = 16'h0, v = 16'h0, addr, wd, rdata, d, a;
  logic [63:0] dp = 64'h0, di = 64'h0;
  logic [3:0]  wi;
  logic [6:0]  un;
  logic [31:0] rs = 32'h1f;
  logic [15:0] mc[NUM_RECORDS], ms[NUM_RECORDS], mv[NUM_RECORDS], ma[NUM_RECORDS];
  logic [63:0] md[NUM_RECORDS];
  int          num_errors = 0, tests_run = 0, wp = 0, acked = 0, n = 0, k, cyc = 0;
  evrup_core #(.NREC(NUM_RECORDS)) u_dut (.i_clk(clk), .i_rstn(rstn), .i_evt_valid(ev), .i_evt_code(c),
    .i_evt_src_addr(s), .i_evt_value(v), .i_evt_date_private(dp), .i_evt_date_iec(di), .o_evt_ready(rdy),
    .i_rd(rd), .i_wr(wr), .i_addr(addr), .i_word(wi), .i_wdata(wd), .o_rdata(rdata), .o_rvalid(),
    .o_unacked(un), .o_manual_mode(mm));
  evrup_master u_m (.i_clk(clk), .i_rdata(rdata), .o_rd(rd), .o_wr(wr), .o_addr(addr), .o_word(wi),
    .o_wdata(wd));
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      num_errors++;
      final_report();
    end
  end
  function automatic logic [15:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[15:0];
  endfunction
  function automatic logic [15:0] ex(int k, logic [3:0] w);
    if (k < 0 || k >= wp) return 16'h0;
    case (w)
      4'h0: return mc[k];
      4'h1: return ms[k];
      4'h2: return mv[k];
      4'h4, 4'h5, 4'h6, 4'h7: return md[k][63 - 16 * (w - 4) -: 16];
      4'h8: return ma[k];
      default: return 16'h0;
    endcase
  endfunction
  function automatic int oldest();
    for (int i = 0; i < wp; i++) if (ma[i] == 16'h0) return i;
    return -1;
  endfunction
  task automatic offer();
    c = (xs() % 16'h3f) + 16'h1;
    s = xs();
    v = xs();
    dp = {xs(), xs(), xs(), xs()};
    di = {xs(), xs(), xs(), xs()};
  endtask
  // date words follow the format in force when the record is taken
  task automatic take();
    mc[wp] = c;
    ms[wp] = s;
    mv[wp] = v;
    md[wp] = fmt ? di : dp;
    ma[wp] = 16'h0;
    wp++;
  endtask
  task automatic push();
    offer();
    ev = 1'b1;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    take();
    #1;
  endtask
  task automatic idle(input int m);
    repeat (m) @(posedge clk);
    #1;
  endtask
  task automatic final_report();
    if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    idle(12);
    rstn = 1'b1;
    idle(2);
    `CHK("unacked", 7'h0, un)
    fork
      u_m.stall(12);
      begin
        offer();
        ev = 1'b1;
        repeat (10) begin
          @(posedge clk);
          if (rdy === 1'b1) begin
            take();
            n++;
            #1 offer();
          end
        end
        #1 ev = 1'b0;
      end
    join
    `CHK("accepted", FIFO_DEPTH, n)
    idle(6);
    u_m.wr(DATEFMT_ADDR, 16'h1);
    fmt = 1'b1;
    repeat (2) push();
    ev = 1'b0;
    idle(6);
    `CHK("unacked", 7'(wp), un)
    for (k = 0; k <= wp; k++) for (int w = 0; w < 10; w++) begin
      u_m.rd(PAGE35_FIRST + 16'(k), 4'(w), d);
      `CHK("page35", ex(k, 4'(w)), d)
    end
    for (int i = 0; i < 3; i++) begin
      a = (i == 0) ? 16'h1000 : (i == 1) ? 16'h354b : PAGE35_LAST;
      u_m.rd(a, 4'(xs()), d);
      `CHK("spare", 16'h0, d)
    end
    `CHK("unacked", 7'(wp), un)
    for (int i = 0; i < 3; i++) begin
      k = oldest();
      for (int w = 0; w < 9; w++) begin
        a = 16'h3600 | (xs() & 16'h00ff);
        u_m.rd(a, 4'(w), d);
        `CHK("page36", ex(k, 4'(w)), d)
      end
      ma[k] = 16'h1;
      acked++;
      `CHK("unacked", 7'(wp - acked), un)
    end
    u_m.wr(CTRL_ADDR, 16'h1000);
    `CHK("mode", 1'b1, mm)
    u_m.rd(16'h3600, ACK_WORD_IDX, d);
    `CHK("flag36", ex(oldest(), ACK_WORD_IDX), d)
    `CHK("unacked", 7'(wp - acked), un)
    while (oldest() >= 0) begin
      u_m.rd(16'h3600, 4'h0, d);
      `CHK("page36", ex(oldest(), 4'h0), d)
      u_m.wr(CTRL_ADDR, 16'h3000);
      ma[oldest()] = 16'h1;
      acked++;
      `CHK("unacked", 7'(wp - acked), un)
    end
    u_m.rd(16'h3600, 4'h0, d);
    `CHK("none left", 16'h0, d)
    u_m.rd(PAGE35_FIRST, ACK_WORD_IDX, d);
    `CHK("ack flag", 16'h1, d)
    final_report();
  end
endmodule
`default_nettype wire
